// ---- src/fpd_bank_top.sv ----
// Purpose: Loop source, feedback, power-down and dynamic delay register bank
// Assumes: Byte register port behind the serial control interface, synchronous to clk_i
// Notes:   Read data appears one cycle after reg_rd_i with reg_rdata_valid_o
`timescale 1ns/1ns
`include "fpd_map.svh"
module fpd_bank_top #(
   parameter int unsigned ADDR_W   = `FPD_ADDR_W,
   parameter int unsigned STEP_GAP = `FPD_STEP_GAP_CYC
) (
   input  wire logic              clk_i,
   input  wire logic              sys_rst_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic [7:0]        reg_wdata_i,
   input  wire logic [1:0]        sync_mode_i,
   output logic      [7:0]        reg_rdata_o,
   output logic                   reg_rdata_valid_o,
   output logic                   second_loop_ref_source_sel_o,
   output logic                   second_loop_ndiv_input_sel_o,
   output logic      [1:0]        first_loop_ndiv_input_sel_o,
   output logic      [1:0]        feedback_source_sel_o,
   output logic                   feedback_selector_power_o,
   output logic                   first_loop_power_down_o,
   output logic                   oscillator_regulator_power_down_o,
   output logic                   vco_power_down_o,
   output logic                   ref_osc_port_power_down_o,
   output logic                   sysref_group_power_down_o,
   output logic                   sysref_block_power_down_o,
   output logic                   sysref_delay_power_down_o,
   output logic                   sysref_pulser_power_down_o,
   output logic      [7:0]        dynamic_delay_enable_o,
   output logic      [7:0]        dynamic_delay_step_o,
   output logic                   dynamic_delay_busy_o,
   output logic                   sysref_burst_request_o
);
   logic [7:0] src_sel_reg;
   logic [7:0] power_down_reg;
   logic [7:0] ddly_en_reg;
   logic [7:0] ddly_steps_reg;
   logic       start_reg;
   logic [7:0] step_out_reg;
   logic       busy_reg;
   logic       burst_reg;
   logic [7:0] rdata_reg;
   logic       rvalid_reg;
   logic [7:0] rdata_next;

   fpd_ddly_if dd ();

   default clocking fpd_cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [12:0] ofs);
      hit = (addr == ADDR_W'(ofs));
   endfunction

   wire wr_src   = reg_wr_i && hit(reg_addr_i, `FPD_OFS_SRC_SEL);
   wire wr_pd    = reg_wr_i && hit(reg_addr_i, `FPD_OFS_POWER_DOWN);
   wire wr_en    = reg_wr_i && hit(reg_addr_i, `FPD_OFS_DDLY_EN);
   wire wr_steps = reg_wr_i && hit(reg_addr_i, `FPD_OFS_DDLY_STEPS);
   wire wr_burst = reg_wr_i && hit(reg_addr_i, `FPD_OFS_BURST_LEN);

   // Source and feedback selection
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         src_sel_reg <= `FPD_RST_SRC_SEL;
      end else if (wr_src) begin
         // Reserved bit is never stored, so it cannot steer anything
         src_sel_reg <= reg_wdata_i & `FPD_SRC_SEL_WR_MASK;
      end
   end

   // Power-down controls; loop, regulator and VCO start powered down
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         power_down_reg <= `FPD_RST_POWER_DOWN;
      end else if (wr_pd) begin
         power_down_reg <= reg_wdata_i;
      end
   end

   // Dynamic delay enables and step count
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ddly_en_reg <= `FPD_RST_DDLY_EN;
      end else if (wr_en) begin
         ddly_en_reg <= reg_wdata_i;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ddly_steps_reg <= `FPD_RST_DDLY_STEPS;
      end else if (wr_steps) begin
         ddly_steps_reg <= reg_wdata_i;
      end
   end

   // The write strobe is the only start source; no pin reaches here
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         start_reg <= 1'b0;
      end else begin
         start_reg <= wr_steps;
      end
   end

   assign dd.start = start_reg;
   assign dd.count = ddly_steps_reg;

   fpd_ddly_engine #(
      .STEP_GAP (STEP_GAP)
   ) u_engine (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .dd        (dd.engine)
   );

   // Steps reach only the paths whose enable is set at the time of each step
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         step_out_reg <= 8'h00;
      end else begin
         step_out_reg <= dd.step ? ddly_en_reg : 8'h00;
      end
   end

   // Busy is re-timed so that the pin comes straight from a flop
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= dd.busy;
      end
   end

   // Pulser burst needs SPI-trigger mode and powered SYSREF block and pulser
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         burst_reg <= 1'b0;
      end else begin
         burst_reg <= wr_burst && (sync_mode_i == `FPD_SYNC_MODE_SPI)
                      && !power_down_reg[`FPD_BIT_SYSREF_BLK_PD]
                      && !power_down_reg[`FPD_BIT_SYSREF_PLS_PD];
      end
   end

   always_comb begin
      rdata_next = 8'h00;
      if (hit(reg_addr_i, `FPD_OFS_SRC_SEL)) begin
         rdata_next = src_sel_reg & `FPD_SRC_SEL_WR_MASK;
      end else if (hit(reg_addr_i, `FPD_OFS_POWER_DOWN)) begin
         rdata_next = power_down_reg;
      end else if (hit(reg_addr_i, `FPD_OFS_DDLY_EN)) begin
         rdata_next = ddly_en_reg;
      end else if (hit(reg_addr_i, `FPD_OFS_DDLY_STEPS)) begin
         rdata_next = ddly_steps_reg;
      end
   end

   // Unmapped addresses read zero; data holds until the next read
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_reg <= 8'h00;
      end else if (reg_rd_i) begin
         rdata_reg <= rdata_next;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= reg_rd_i;
      end
   end

   assign reg_rdata_o                       = rdata_reg;
   assign reg_rdata_valid_o                 = rvalid_reg;
   assign second_loop_ref_source_sel_o      = src_sel_reg[`FPD_BIT_REF_SRC];
   assign second_loop_ndiv_input_sel_o      = src_sel_reg[`FPD_BIT_NDIV2_SRC];
   assign first_loop_ndiv_input_sel_o       = src_sel_reg[`FPD_FLD_NDIV1_HI:`FPD_FLD_NDIV1_LO];
   assign feedback_source_sel_o             = src_sel_reg[`FPD_FLD_FB_HI:`FPD_FLD_FB_LO];
   assign feedback_selector_power_o         = src_sel_reg[`FPD_BIT_FB_POWER];
   assign first_loop_power_down_o           = power_down_reg[`FPD_BIT_LOOP1_PD];
   assign oscillator_regulator_power_down_o = power_down_reg[`FPD_BIT_REGULATOR_PD];
   assign vco_power_down_o                  = power_down_reg[`FPD_BIT_VCO_POWER_DOWN];
   assign ref_osc_port_power_down_o         = power_down_reg[`FPD_BIT_OSC_PORT_PD];
   assign sysref_group_power_down_o         = power_down_reg[`FPD_BIT_SYSREF_GRP_PD];
   assign sysref_block_power_down_o         = power_down_reg[`FPD_BIT_SYSREF_BLK_PD];
   assign sysref_delay_power_down_o         = power_down_reg[`FPD_BIT_SYSREF_DLY_PD];
   assign sysref_pulser_power_down_o        = power_down_reg[`FPD_BIT_SYSREF_PLS_PD];
   assign dynamic_delay_enable_o            = ddly_en_reg;
   assign dynamic_delay_step_o              = step_out_reg;
   assign dynamic_delay_busy_o              = busy_reg;
   assign sysref_burst_request_o            = burst_reg;

   a_ref_source_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_src |=> second_loop_ref_source_sel_o == $past(reg_wdata_i[7]))
      else $error("second loop reference select not updated");
   a_ndiv_sources_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_src |=> second_loop_ndiv_input_sel_o == $past(reg_wdata_i[5])
                 && first_loop_ndiv_input_sel_o == $past(reg_wdata_i[4:3]))
      else $error("N divider source selects not updated");
   a_feedback_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_src |=> feedback_source_sel_o == $past(reg_wdata_i[2:1])
                 && feedback_selector_power_o == $past(reg_wdata_i[0]))
      else $error("feedback selector fields not updated");
   a_reserved_reads_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      reg_rd_i && hit(reg_addr_i, `FPD_OFS_SRC_SEL) |=> reg_rdata_valid_o && !reg_rdata_o[6])
      else $error("reserved source bit read back set");
   a_power_down_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_pd |=> {first_loop_power_down_o, oscillator_regulator_power_down_o, vco_power_down_o,
                 ref_osc_port_power_down_o, sysref_group_power_down_o, sysref_block_power_down_o,
                 sysref_delay_power_down_o, sysref_pulser_power_down_o} == $past(reg_wdata_i))
      else $error("power-down bits not updated");
   a_step_write_starts: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_steps && reg_wdata_i != 8'h00 |-> ##3 dynamic_delay_busy_o)
      else $error("step count write did not start adjustment");
   a_zero_no_adjust: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_steps && reg_wdata_i == 8'h00 && !dd.busy && !start_reg |-> ##2 !dd.busy [*4])
      else $error("zero step count started adjustment");
   a_start_only_by_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $rose(dd.busy) |-> $past(wr_steps, 2))
      else $error("adjustment started without a step count write");
   a_steps_masked: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (dynamic_delay_step_o & ~$past(ddly_en_reg)) == 8'h00)
      else $error("step reached a disabled path");
   a_burst_on_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      sysref_burst_request_o |-> $past(wr_burst) && $past(sync_mode_i) == `FPD_SYNC_MODE_SPI)
      else $error("burst request without burst length write in mode 3");

   // Stored settings move only on a write to their own offset
   a_source_holds: assert property (
      !wr_src |=> $stable(src_sel_reg))
      else $error("source select changed without a write");
   a_power_holds: assert property (
      !wr_pd |=> $stable(power_down_reg))
      else $error("power-down bits changed without a write");
   a_enables_hold: assert property (
      !wr_en |=> $stable(ddly_en_reg))
      else $error("dynamic delay enables changed without a write");
   a_steps_hold: assert property (
      !wr_steps |=> $stable(ddly_steps_reg))
      else $error("step count changed without a write");
   a_enable_write: assert property (
      wr_en |=> dynamic_delay_enable_o == $past(reg_wdata_i))
      else $error("dynamic delay enables not updated");

   // Read data is the stored value at the read edge
   a_read_power: assert property (
      reg_rd_i && hit(reg_addr_i, `FPD_OFS_POWER_DOWN) |=> reg_rdata_o == $past(power_down_reg))
      else $error("power-down read back wrong");
   a_read_enables: assert property (
      reg_rd_i && hit(reg_addr_i, `FPD_OFS_DDLY_EN) |=> reg_rdata_o == $past(ddly_en_reg))
      else $error("enable read back wrong");
   a_read_steps: assert property (
      reg_rd_i && hit(reg_addr_i, `FPD_OFS_DDLY_STEPS) |=> reg_rdata_o == $past(ddly_steps_reg))
      else $error("step count read back wrong");

   // Only the register strobe may start the engine
   a_start_needs_write: assert property (
      dd.start |-> $past(wr_steps))
      else $error("engine start without a step count write");
   a_start_runs: assert property (
      dd.start && dd.count != 8'h00 |=> dd.busy)
      else $error("nonzero start left the engine idle");

   // Burst requests follow the mode and the SYSREF power state
   a_burst_when_armed: assert property (
      wr_burst && sync_mode_i == `FPD_SYNC_MODE_SPI && !power_down_reg[`FPD_BIT_SYSREF_BLK_PD]
      && !power_down_reg[`FPD_BIT_SYSREF_PLS_PD] |=> sysref_burst_request_o)
      else $error("armed burst length write gave no request");
   a_burst_blocked: assert property (
      wr_burst && power_down_reg[`FPD_BIT_SYSREF_BLK_PD] |=> !sysref_burst_request_o)
      else $error("burst request with SYSREF block powered down");
   a_pulser_blocked: assert property (
      wr_burst && power_down_reg[`FPD_BIT_SYSREF_PLS_PD] |=> !sysref_burst_request_o)
      else $error("burst request with pulser powered down");

   c_steps_to_sysref: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      dynamic_delay_step_o[7] ##[1:20] dynamic_delay_step_o[7]);
   c_burst_request: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      sysref_burst_request_o);
   c_restart_mid_run: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      dd.busy && wr_steps);
   c_zero_delay_powered: cover property (
      wr_src && reg_wdata_i[`FPD_BIT_FB_POWER]);
endmodule

// ---- src/fpd_map.svh ----
// Purpose: Register offsets, reset values, field positions and timing counts of the loop/power/dynamic delay bank
// Assumes: Byte-wide registers at their printed word addresses
// Notes:   Definitions only
`ifndef FPD_MAP_SVH
`define FPD_MAP_SVH

`define FPD_ADDR_W             13
`define FPD_OFS_SRC_SEL        13'h013F
`define FPD_OFS_POWER_DOWN     13'h0140
`define FPD_OFS_DDLY_EN        13'h0141
`define FPD_OFS_DDLY_STEPS     13'h0142
`define FPD_OFS_BURST_LEN      13'h013E

`define FPD_RST_SRC_SEL        8'h00
`define FPD_RST_POWER_DOWN     8'hE0
`define FPD_RST_DDLY_EN        8'h00
`define FPD_RST_DDLY_STEPS     8'h00
`define FPD_SRC_SEL_WR_MASK    8'hBF

`define FPD_BIT_REF_SRC        7
`define FPD_BIT_NDIV2_SRC      5
`define FPD_FLD_NDIV1_HI       4
`define FPD_FLD_NDIV1_LO       3
`define FPD_FLD_FB_HI          2
`define FPD_FLD_FB_LO          1
`define FPD_BIT_FB_POWER       0

`define FPD_BIT_LOOP1_PD       7
`define FPD_BIT_REGULATOR_PD   6
`define FPD_BIT_VCO_POWER_DOWN         5
`define FPD_BIT_OSC_PORT_PD    4
`define FPD_BIT_SYSREF_GRP_PD  3
`define FPD_BIT_SYSREF_BLK_PD  2
`define FPD_BIT_SYSREF_DLY_PD  1
`define FPD_BIT_SYSREF_PLS_PD  0

`define FPD_SYNC_MODE_SPI      2'h3
`define FPD_STEP_GAP_CYC       4

`endif

// ---- src/fpd_pkg.sv ----
// Purpose: Shared types of the loop/power/dynamic delay bank
// Assumes: Nothing beyond the map header
// Notes:   One-hot state codes are written out
package fpd_pkg;
   typedef enum logic [1:0] {
      FPD_SEQ_IDLE = 2'h1,
      FPD_SEQ_RUN  = 2'h2
   } fpd_seq_state_type;
endpackage

// ---- src/fpd_ddly_if.sv ----
// Purpose: Link between the register bank and the dynamic delay step engine
// Assumes: Single clock domain
// Notes:   start is a one-cycle pulse carrying count
`timescale 1ns/1ns
interface fpd_ddly_if;
   logic       start;
   logic [7:0] count;
   logic       busy;
   logic       step;
   modport ctrl   (output start, output count, input busy, input step);
   modport engine (input start, input count, output busy, output step);
endinterface

// ---- src/fpd_ddly_engine.sv ----
// Purpose: Issues the requested number of dynamic delay steps
// Assumes: start only ever comes from a register write
// Notes:   A new start during a run restarts with the new count
`timescale 1ns/1ns
`include "fpd_map.svh"
module fpd_ddly_engine #(
   parameter int unsigned STEP_GAP = `FPD_STEP_GAP_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   fpd_ddly_if.engine       dd
);
   localparam logic [7:0] GAP_LAST = 8'(STEP_GAP - 1);

   fpd_pkg::fpd_seq_state_type state_reg;
   logic [7:0]                 remaining_reg;
   logic [7:0]                 gap_reg;
   logic                       step_reg;
   logic [8:0]                 steps_done_reg;
   logic [7:0]                 loaded_reg;

   wire fire = (state_reg == fpd_pkg::FPD_SEQ_RUN) && (gap_reg == 8'h00);

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= fpd_pkg::FPD_SEQ_IDLE;
      end else if (dd.start) begin
         // Zero means no adjustment at all
         state_reg <= (dd.count != 8'h00) ? fpd_pkg::FPD_SEQ_RUN : fpd_pkg::FPD_SEQ_IDLE;
      end else begin
         case (state_reg)
            fpd_pkg::FPD_SEQ_RUN: begin
               if (fire && remaining_reg == 8'h01) begin
                  state_reg <= fpd_pkg::FPD_SEQ_IDLE;
               end
            end
            default: state_reg <= fpd_pkg::FPD_SEQ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         remaining_reg <= 8'h00;
         gap_reg       <= 8'h00;
         loaded_reg    <= 8'h00;
      end else if (dd.start) begin
         remaining_reg <= dd.count;
         gap_reg       <= GAP_LAST;
         loaded_reg    <= dd.count;
      end else if (state_reg == fpd_pkg::FPD_SEQ_RUN) begin
         gap_reg <= (gap_reg == 8'h00) ? GAP_LAST : gap_reg - 8'h01;
         if (fire) begin
            remaining_reg <= remaining_reg - 8'h01;
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         step_reg <= 1'b0;
      end else begin
         step_reg <= fire && !dd.start;
      end
   end

   // Step tally only feeds the checks below
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         steps_done_reg <= 9'h000;
      end else if (dd.start) begin
         steps_done_reg <= 9'h000;
      end else if (fire) begin
         steps_done_reg <= steps_done_reg + 9'h001;
      end
   end

   assign dd.busy = (state_reg == fpd_pkg::FPD_SEQ_RUN);
   assign dd.step = step_reg;

   a_step_total_exact: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $fell(dd.busy) && !$past(dd.start) |-> steps_done_reg == {1'b0, loaded_reg})
      else $error("step total differs from requested count");
   a_step_spacing: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      dd.step && !dd.start |=> !dd.step [*3])
      else $error("steps closer than the step gap");
   c_multi_step_run: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      dd.start && dd.count > 8'h02 ##1 dd.busy [*8]);
endmodule

// ---- tb/fpd_host_model.sv ----
// Purpose: Serial control host stand-in driving the byte register port
// Assumes: Requests launched and released at the falling edge of clk_i
// Notes:   Idle address and data lines carry the inverse of the last value
`timescale 1ns/1ns
`include "fpd_map.svh"
module fpd_host_model #(
   parameter int unsigned ADDR_W = 13
) (
   input  wire logic              clk_i,
   output logic                   reg_wr_o,
   output logic                   reg_rd_o,
   output logic      [ADDR_W-1:0] reg_addr_o,
   output logic      [7:0]        reg_wdata_o,
   output logic      [1:0]        sync_mode_o,
   input  wire logic [7:0]        reg_rdata_i,
   input  wire logic              reg_rdata_valid_i
);
   initial begin
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      reg_addr_o  = '0;
      reg_wdata_o = 8'h00;
      sync_mode_o = 2'h1;
   end

   task automatic write_reg(input logic [ADDR_W-1:0] addr, input logic [7:0] data);
      @(negedge clk_i);
      reg_wr_o    = 1'b1;
      reg_addr_o  = addr;
      reg_wdata_o = data;
      @(negedge clk_i);
      reg_wr_o    = 1'b0;
      reg_addr_o  = ~addr;
      reg_wdata_o = ~data;
   endtask

   task automatic read_reg(input logic [ADDR_W-1:0] addr, output logic [7:0] data, output logic valid);
      @(negedge clk_i);
      reg_rd_o   = 1'b1;
      reg_addr_o = addr;
      @(negedge clk_i);
      // Valid stands one cycle only, so take the answer before letting go
      data       = reg_rdata_i;
      valid      = reg_rdata_valid_i;
      reg_rd_o   = 1'b0;
      reg_addr_o = ~addr;
   endtask

   task automatic set_mode(input logic [1:0] mode);
      @(negedge clk_i);
      sync_mode_o = mode;
   endtask

   // Mode 3 goes out first, though the bank takes the step write in any mode
   task automatic write_steps(input logic [7:0] count);
      set_mode(`FPD_SYNC_MODE_SPI);
      write_reg(`FPD_OFS_DDLY_STEPS, count);
   endtask

   // Feedback selector power always set together with the source choice
   task automatic zero_delay_select(input logic [1:0] source);
      write_reg(`FPD_OFS_SRC_SEL, {5'h00, source, 1'b1});
   endtask
endmodule

// ---- tb/fpd_bank_top_tb_top.sv ----
// Purpose: Self-checking bench for the loop source, power-down and dynamic delay bank
// Assumes: Host stand-in owns every register port input
// Notes:   Pulses are counted at every falling edge, so none is missed or seen twice
`timescale 1ns/1ns
`include "fpd_map.svh"
module fpd_bank_top_tb_top;
   localparam int unsigned ADDR_W   = 13;
   localparam int unsigned STEP_GAP = 4;
   localparam logic [7:0]  SRC_VALS [8] = '{8'h80, 8'h20, 8'h08, 8'h10, 8'h06, 8'h02, 8'h40, 8'hFF};
   localparam logic [7:0]  STEP_CNTS [4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
   logic              clk_i;
   logic              sys_rst_i;
   logic              reg_wr;
   logic              reg_rd;
   logic [ADDR_W-1:0] reg_addr;
   logic [7:0]        reg_wdata;
   logic [1:0]        sync_mode;
   logic [7:0]        rdata;
   logic              rvalid;
   wire  [7:0]        src_vec;
   wire  [7:0]        pd_vec;
   logic [7:0]        dd_en;
   logic [7:0]        dd_step;
   logic              busy;
   logic              burst_req;
   logic [7:0]        exp_en;
   int                miscompares = 0;
   int                num_checks = 0;
   int                steps_seen = 0;
   int                bursts_seen = 0;

   assign src_vec[6] = 1'b0;

   fpd_bank_top #(.ADDR_W(ADDR_W), .STEP_GAP(STEP_GAP)) fpd_bank_top_inst (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .sync_mode_i(sync_mode),
      .reg_rdata_o(rdata), .reg_rdata_valid_o(rvalid),
      .second_loop_ref_source_sel_o(src_vec[7]), .second_loop_ndiv_input_sel_o(src_vec[5]),
      .first_loop_ndiv_input_sel_o(src_vec[4:3]), .feedback_source_sel_o(src_vec[2:1]),
      .feedback_selector_power_o(src_vec[0]), .first_loop_power_down_o(pd_vec[7]),
      .oscillator_regulator_power_down_o(pd_vec[6]), .vco_power_down_o(pd_vec[5]),
      .ref_osc_port_power_down_o(pd_vec[4]), .sysref_group_power_down_o(pd_vec[3]),
      .sysref_block_power_down_o(pd_vec[2]), .sysref_delay_power_down_o(pd_vec[1]),
      .sysref_pulser_power_down_o(pd_vec[0]), .dynamic_delay_enable_o(dd_en),
      .dynamic_delay_step_o(dd_step), .dynamic_delay_busy_o(busy), .sysref_burst_request_o(burst_req));

   fpd_host_model #(.ADDR_W(ADDR_W)) fpd_host_model_inst (
      .clk_i(clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr),
      .reg_wdata_o(reg_wdata), .sync_mode_o(sync_mode), .reg_rdata_i(rdata), .reg_rdata_valid_i(rvalid));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results;
      $display("Checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic rd_check(input string what, input logic [ADDR_W-1:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      logic       v;
      fpd_host_model_inst.read_reg(addr, d, v);
      check(what, d, exp);
      check("read valid", {7'h00, v}, 8'h01);
   endtask

   // Waits for the step run to finish; a hang ends the run at once
   task automatic wait_idle(input int bound);
      int n;
      n = 0;
      while (busy !== 1'b0 && n < bound) begin
         @(negedge clk_i);
         n++;
      end
      if (busy !== 1'b0) begin
         miscompares++;
         $display("[FAIL] busy expected 0 seen 1");
         results();
      end
   endtask

   always @(negedge clk_i) begin
      if (!sys_rst_i && dd_step !== 8'h00) begin
         steps_seen++;
         check("step enables", dd_step, exp_en);
      end
      if (!sys_rst_i && burst_req !== 1'b0) begin
         bursts_seen++;
      end
   end

   initial begin
      logic [7:0] v;
      sys_rst_i = 1'b1;
      exp_en    = 8'h00;
      repeat (10) @(negedge clk_i);
      sys_rst_i = 1'b0;
      check("power-down outputs", pd_vec, `FPD_RST_POWER_DOWN);
      rd_check("source reg", `FPD_OFS_SRC_SEL, 8'h00);
      rd_check("power reg", `FPD_OFS_POWER_DOWN, 8'hE0);
      rd_check("enable reg", `FPD_OFS_DDLY_EN, 8'h00);
      rd_check("step reg", `FPD_OFS_DDLY_STEPS, 8'h00);
      rd_check("unmapped", 13'h0150, 8'h00);
      $display("Test reset done");
      for (int s = 0; s < 4; s++) begin
         fpd_host_model_inst.zero_delay_select(s[1:0]);
         check("feedback outputs", src_vec, {5'h00, s[1:0], 1'b1});
      end
      foreach (SRC_VALS[i]) begin
         fpd_host_model_inst.write_reg(`FPD_OFS_SRC_SEL, SRC_VALS[i]);
         check("source outputs", src_vec, SRC_VALS[i] & 8'hBF);
         rd_check("source reg", `FPD_OFS_SRC_SEL, SRC_VALS[i] & 8'hBF);
      end
      $display("Test source select done");
      for (int i = 0; i <= 8; i++) begin
         v = (i == 8) ? 8'h00 : (8'h01 << i);
         fpd_host_model_inst.write_reg(`FPD_OFS_POWER_DOWN, v);
         check("power-down outputs", pd_vec, v);
         rd_check("power reg", `FPD_OFS_POWER_DOWN, v);
      end
      fpd_host_model_inst.write_reg(13'h0143, 8'hFF);
      check("power after unmapped", pd_vec, 8'h00);
      $display("Test power-down done");
      for (int i = 0; i < 2; i++) begin
         v = i ? 8'h5A : 8'hA5;
         fpd_host_model_inst.write_reg(`FPD_OFS_DDLY_EN, v);
         check("enable outputs", dd_en, v);
         rd_check("enable reg", `FPD_OFS_DDLY_EN, v);
      end
      exp_en = 8'h81;
      fpd_host_model_inst.write_reg(`FPD_OFS_DDLY_EN, exp_en);
      foreach (STEP_CNTS[i]) begin
         steps_seen = 0;
         fpd_host_model_inst.write_steps(STEP_CNTS[i]);
         repeat (3) @(negedge clk_i);
         check("busy", {7'h00, busy}, {7'h00, STEP_CNTS[i] != 8'h00});
         wait_idle(int'(STEP_CNTS[i]) * STEP_GAP + 16);
         repeat (2) @(negedge clk_i);
         check("step total", 8'(steps_seen), STEP_CNTS[i]);
      end
      // Second write lands before the first step, so only its count runs
      steps_seen = 0;
      fpd_host_model_inst.write_steps(8'h08);
      fpd_host_model_inst.write_reg(`FPD_OFS_DDLY_STEPS, 8'h02);
      wait_idle(60);
      repeat (2) @(negedge clk_i);
      check("restart total", 8'(steps_seen), 8'h02);
      steps_seen = 0;
      fpd_host_model_inst.set_mode(2'h0);
      fpd_host_model_inst.write_reg(`FPD_OFS_DDLY_EN, 8'hFF);
      fpd_host_model_inst.write_reg(`FPD_OFS_BURST_LEN, 8'h03);
      repeat (12) @(negedge clk_i);
      check("no stray steps", 8'(steps_seen), 8'h00);
      $display("Test dynamic delay done");
      fpd_host_model_inst.write_reg(`FPD_OFS_POWER_DOWN, 8'h00);
      for (int m = 0; m < 4; m++) begin
         bursts_seen = 0;
         fpd_host_model_inst.set_mode(m[1:0]);
         fpd_host_model_inst.write_reg(`FPD_OFS_BURST_LEN, 8'h01);
         repeat (2) @(negedge clk_i);
         check("burst count", 8'(bursts_seen), {7'h00, m == 3});
      end
      for (int i = 0; i < 2; i++) begin
         bursts_seen = 0;
         fpd_host_model_inst.write_reg(`FPD_OFS_POWER_DOWN, i ? 8'h04 : 8'h01);
         fpd_host_model_inst.write_reg(`FPD_OFS_BURST_LEN, 8'h02);
         repeat (2) @(negedge clk_i);
         check("gated burst", 8'(bursts_seen), 8'h00);
      end
      $display("Test burst done");
      results();
   end
endmodule
